// *** common/fsbe_map.svh ***
// Constants for the file-op, skip and branch execution datapath
`ifndef FSBE_MAP_SVH
`define FSBE_MAP_SVH

`define FSBE_FILE_DEPTH 128
`define FSBE_ADDR_W 7
`define FSBE_DATA_W 8
`define FSBE_PC_W 15
`define FSBE_TARGET_W 11
`define FSBE_LATCH_HI 6
`define FSBE_LATCH_LO 3
`define FSBE_DEST_ACCUM 1'b0
`define FSBE_DEST_FILE 1'b1
`define FSBE_BYTE_ZERO 8'h00
`define FSBE_BYTE_ONE 8'h01
`define FSBE_PC_RESET 15'h0000
`define FSBE_PC_STEP 15'h0001

`endif

// *** common/fsbe_pkg.sv ***
// Types for the file-op, skip and branch execution datapath
package fsbe_pkg;

  typedef enum logic [2:0] {
    nop_op = 3'h0,
    decrement_skip_zero_op = 3'h1,
    increment_skip_zero_op = 3'h2,
    unconditional_branch_op = 3'h3,
    or_literal_accum_op = 3'h4,
    increment_file_op = 3'h5,
    or_accum_file_op = 3'h6,
    call_subroutine_op = 3'h7
  } fsbe_op_type;

  typedef enum logic [0:0] {
    ST_EXEC = 1'h0,
    ST_FLUSH = 1'h1
  } fsbe_state_type;

endpackage

// *** dv/fsbe_exec_checker.sv ***
// Assertion checker for the execution datapath
`timescale 1ns/1ps
`default_nettype none
module fsbe_exec_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic instrValid,
  input wire fsbe_pkg::fsbe_op_type instrOp,
  input wire logic [6:0] fileAddr,
  input wire logic destSel,
  input wire logic [7:0] literal,
  input wire logic [10:0] branchTarget,
  input wire logic [7:0] pc_high_latch,
  input wire logic [7:0] accum_q,
  input wire logic zeroFlag_q,
  input wire logic [14:0] pc_q,
  input wire logic squash_q,
  input wire logic stackPush_q,
  input wire logic [14:0] stackData_q,
  input wire logic fileWrEn_q,
  input wire logic [6:0] fileWrAddr_q,
  input wire logic [7:0] fileWrData_q
);
  import fsbe_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire ex = instrValid && !squash_q;
  wire skipOp = instrOp inside {decrement_skip_zero_op,
    increment_skip_zero_op};
  wire brOp = instrOp inside {unconditional_branch_op, call_subroutine_op};
  chk_branch_pc: assert property (
    ex && instrOp == unconditional_branch_op |=>
    pc_q == {$past(pc_high_latch[6:3]), $past(branchTarget)})
    else $error("branch pc");
  chk_branch_discard: assert property (
    ex && brOp |=> squash_q) else $error("branch discard");
  chk_squash_nop: assert property (
    instrValid && squash_q |=> !squash_q && !fileWrEn_q &&
    pc_q == $past(pc_q) + 15'h1 && $stable(accum_q))
    else $error("squash slot");
  chk_or_literal: assert property (
    ex && instrOp == or_literal_accum_op |=>
    accum_q == ($past(accum_q) | $past(literal)) &&
    zeroFlag_q == (accum_q == 8'h00)) else $error("or literal");
  chk_skip_flags: assert property (
    ex && skipOp |=> $stable(zeroFlag_q)) else $error("skip flag");
  chk_skip_zero: assert property (
    ex && skipOp |=> squash_q ==
    (($past(destSel) ? fileWrData_q : accum_q) == 8'h00))
    else $error("skip zero");
  chk_file_dest: assert property (
    ex && destSel && instrOp inside {decrement_skip_zero_op,
    increment_skip_zero_op, increment_file_op, or_accum_file_op} |=>
    fileWrEn_q && fileWrAddr_q == $past(fileAddr) && $stable(accum_q))
    else $error("file dest");
  chk_call_push: assert property (
    ex && instrOp == call_subroutine_op |=>
    stackPush_q && stackData_q == $past(pc_q) + 15'h1)
    else $error("call push");
  cover property (ex && instrOp == unconditional_branch_op);
  cover property (ex && skipOp ##1 squash_q);
  cover property (ex && instrOp == call_subroutine_op);
endmodule
bind fsbe_exec fsbe_exec_checker u_fsbe_exec_checker (.clock, .sys_rst,
  .instrValid, .instrOp, .fileAddr, .destSel, .literal, .branchTarget,
  .pc_high_latch, .accum_q, .zeroFlag_q, .pc_q, .squash_q, .stackPush_q,
  .stackData_q, .fileWrEn_q, .fileWrAddr_q, .fileWrData_q);
`default_nettype wire

// *** dv/fsbe_exec_test.sv ***
// Self-checking bench for the execution datapath
`timescale 1ns/1ps
`default_nettype none
module fsbe_exec_test;
  import fsbe_pkg::*;
  typedef struct {fsbe_op_type o; logic [6:0] a; logic d;
    logic [7:0] k, acc; logic z; logic e; logic [7:0] w;} fsbe_row_type;
  localparam fsbe_op_type OL = or_literal_accum_op, OF = or_accum_file_op,
    IS = increment_skip_zero_op, DS = decrement_skip_zero_op,
    IN = increment_file_op;
  logic clock = 0, sys_rst = 1, instrValid = 0, destSel = 0;
  fsbe_op_type instrOp = nop_op;
  logic [6:0] fileAddr = 0, fileWrAddr_q;
  logic [7:0] literal = 0, pc_high_latch = 0, accum_q, fileWrData_q;
  logic [10:0] branchTarget = 0;
  logic [14:0] pc_q, stackData_q;
  logic zeroFlag_q, squash_q, stackPush_q, fileWrEn_q;
  int checks = 0, n_fail = 0;
  fsbe_row_type rows[22] = '{
    '{OL,5,0,8'h00,8'h00,1,0,8'h00}, '{OL,5,0,8'hff,8'hff,0,0,8'h00},
    '{OF,5,1,8'h00,8'hff,0,1,8'hff}, '{IS,5,1,8'h00,8'hff,0,1,8'h00},
    '{IN,5,0,8'h00,8'hff,0,0,8'h00}, '{IN,5,0,8'h00,8'h01,0,0,8'h00},
    '{IN,5,1,8'h00,8'h01,0,1,8'h01}, '{DS,5,0,8'h00,8'h00,0,0,8'h01},
    '{OL,5,0,8'h0f,8'h00,0,0,8'h01}, '{OL,5,0,8'h00,8'h00,1,0,8'h01},
    '{IS,5,0,8'h00,8'h02,1,0,8'h01}, '{DS,5,1,8'h00,8'h02,1,1,8'h00},
    '{IN,5,0,8'h00,8'h02,1,0,8'h00}, '{IN,5,0,8'h00,8'h01,0,0,8'h00},
    '{DS,5,1,8'h00,8'h01,0,1,8'hff}, '{IN,5,0,8'h00,8'h00,1,0,8'hff},
    '{IS,5,1,8'h00,8'h00,1,1,8'h00}, '{OL,5,0,8'hff,8'h00,1,0,8'h00},
    '{IN,5,1,8'h00,8'h00,0,1,8'h01}, '{DS,5,1,8'h00,8'h00,0,1,8'h00},
    '{OL,5,0,8'hff,8'h00,0,0,8'h00}, '{OF,5,0,8'h00,8'h00,1,0,8'h00}};
  fsbe_exec u_fsbe_exec (.clock, .sys_rst, .instrValid, .instrOp,
    .fileAddr, .destSel, .literal, .branchTarget, .pc_high_latch,
    .accum_q, .zeroFlag_q, .pc_q, .squash_q, .stackPush_q, .stackData_q,
    .fileWrEn_q, .fileWrAddr_q, .fileWrData_q);
  initial begin
    forever #4 clock = ~clock;
  end
  task chk(logic [14:0] s, logic [14:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task run(fsbe_op_type o, logic [6:0] a, logic d, logic [7:0] k);
    instrOp = o;
    fileAddr = a;
    destSel = d;
    literal = k;
    instrValid = 1;
    @(posedge clock);
    #1;
  endtask
  task results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #5000;
    n_fail++;
    results;
  end
  initial begin
    repeat (2) @(posedge clock);
    #1 sys_rst = 0;
    foreach (rows[i]) begin
      run(rows[i].o, rows[i].a, rows[i].d, rows[i].k);
      chk(accum_q, rows[i].acc);
      chk(zeroFlag_q, rows[i].z);
      chk(pc_q, 15'(i + 1));
      chk(fileWrEn_q, rows[i].e);
      chk(fileWrData_q, rows[i].w);
      if (rows[i].e) chk(fileWrAddr_q, rows[i].a);
    end
    $display("table done");
    branchTarget = 11'h7ff;
    pc_high_latch = 8'hb8;
    run(unconditional_branch_op, 5, 0, 8'h00);
    chk(pc_q, 15'h3fff);
    chk(squash_q, 1);
    run(OL, 5, 0, 8'hff);
    chk(pc_q, 15'h4000);
    chk(accum_q, 8'h00);
    branchTarget = 11'h123;
    run(call_subroutine_op, 5, 0, 8'h00);
    chk(stackPush_q, 1);
    chk(stackData_q, 15'h4001);
    chk(pc_q, 15'h3923);
    instrValid = 0;
    sys_rst = 1;
    @(posedge clock);
    #1;
    chk(pc_q, 15'h0000);
    chk(squash_q, 0);
    $display("branch, call and reset done");
    results;
  end
endmodule
`default_nettype wire

// *** rtl/fsbe_exec.sv ***
// Execution datapath for file ops with skip, OR ops and branches
`timescale 1ns/1ps
`default_nettype none
`include "fsbe_map.svh"

module fsbe_exec (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic instrValid,
  input wire fsbe_pkg::fsbe_op_type instrOp,
  input wire logic [`FSBE_ADDR_W-1:0] fileAddr,
  input wire logic destSel,
  input wire logic [`FSBE_DATA_W-1:0] literal,
  input wire logic [`FSBE_TARGET_W-1:0] branchTarget,
  input wire logic [`FSBE_DATA_W-1:0] pc_high_latch,
  output logic [`FSBE_DATA_W-1:0] accum_q,
  output logic zeroFlag_q,
  output logic [`FSBE_PC_W-1:0] pc_q,
  output logic squash_q,
  output logic stackPush_q,
  output logic [`FSBE_PC_W-1:0] stackData_q,
  output logic fileWrEn_q,
  output logic [`FSBE_ADDR_W-1:0] fileWrAddr_q,
  output logic [`FSBE_DATA_W-1:0] fileWrData_q
);
  import fsbe_pkg::*;

  logic [`FSBE_DATA_W-1:0] fileMem [`FSBE_FILE_DEPTH];
  fsbe_state_type state_q;
  fsbe_state_type state_d;
  logic [`FSBE_DATA_W-1:0] fileVal;
  logic [`FSBE_DATA_W-1:0] result;
  logic execNow;
  logic writesResult;
  logic setsZero;
  logic skipHit;
  logic takesBranch;
  logic isCall;
  logic [`FSBE_PC_W-1:0] pcNext;
  logic [`FSBE_PC_W-1:0] branchPc;

  // Wraps modulo 256 by keeping only the byte
  function automatic logic [`FSBE_DATA_W-1:0] stepByte(
    input logic [`FSBE_DATA_W-1:0] value,
    input logic up
  );
    stepByte = up ? value + `FSBE_BYTE_ONE : value - `FSBE_BYTE_ONE;
  endfunction

  function automatic logic isZero(input logic [`FSBE_DATA_W-1:0] value);
    isZero = (value == `FSBE_BYTE_ZERO);
  endfunction

  assign fileVal = fileMem[fileAddr];
  assign execNow = instrValid && (state_q == ST_EXEC);
  assign pcNext = pc_q + `FSBE_PC_STEP;
  assign branchPc = {pc_high_latch[`FSBE_LATCH_HI:`FSBE_LATCH_LO],
                     branchTarget};

  always_comb begin
    result = `FSBE_BYTE_ZERO;
    writesResult = 1'b0;
    setsZero = 1'b0;
    skipHit = 1'b0;
    takesBranch = 1'b0;
    isCall = 1'b0;
    case (instrOp)
      decrement_skip_zero_op: begin
        result = stepByte(fileVal, 1'b0);
        writesResult = 1'b1;
        skipHit = isZero(result);
      end
      increment_skip_zero_op: begin
        result = stepByte(fileVal, 1'b1);
        writesResult = 1'b1;
        skipHit = isZero(result);
      end
      unconditional_branch_op: begin
        takesBranch = 1'b1;
      end
      or_literal_accum_op: begin
        result = accum_q | literal;
        setsZero = 1'b1;
      end
      increment_file_op: begin
        result = stepByte(fileVal, 1'b1);
        writesResult = 1'b1;
        setsZero = 1'b1;
      end
      or_accum_file_op: begin
        result = accum_q | fileVal;
        writesResult = 1'b1;
        setsZero = 1'b1;
      end
      call_subroutine_op: begin
        takesBranch = 1'b1;
        isCall = 1'b1;
      end
      default: begin
        result = `FSBE_BYTE_ZERO;
      end
    endcase
  end

  // Skip and branch turn the next slot into a no-operation
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_EXEC: begin
        if (execNow && (skipHit || takesBranch)) begin
          state_d = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        // Idle cycles keep the pending squash
        if (instrValid) begin
          state_d = ST_EXEC;
        end
      end
      default: begin
        state_d = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= ST_EXEC;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      squash_q <= 1'b0;
    end else begin
      squash_q <= (state_d == ST_FLUSH);
    end
  end

  // Accumulator and zero flag
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      accum_q <= `FSBE_BYTE_ZERO;
      zeroFlag_q <= 1'b0;
    end else if (execNow) begin
      if (instrOp == or_literal_accum_op) begin
        accum_q <= result;
      end else if (writesResult && destSel == `FSBE_DEST_ACCUM) begin
        accum_q <= result;
      end
      if (setsZero) begin
        zeroFlag_q <= isZero(result);
      end
    end
  end

  // File register array and its write report
  // Array contents are not reset
  always_ff @(posedge clock) begin
    if (execNow && writesResult && destSel == `FSBE_DEST_FILE) begin
      fileMem[fileAddr] <= result;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fileWrEn_q <= 1'b0;
      fileWrAddr_q <= '0;
      fileWrData_q <= `FSBE_BYTE_ZERO;
    end else begin
      fileWrEn_q <= execNow && writesResult && destSel == `FSBE_DEST_FILE;
      if (execNow && writesResult && destSel == `FSBE_DEST_FILE) begin
        fileWrAddr_q <= fileAddr;
        fileWrData_q <= result;
      end
    end
  end

  // Program counter and return push
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pc_q <= `FSBE_PC_RESET;
    end else if (instrValid) begin
      // A squashed slot still advances by one
      if (execNow && takesBranch) begin
        pc_q <= branchPc;
      end else begin
        pc_q <= pcNext;
      end
    end
  end

  // Return address is the slot after the call
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stackPush_q <= 1'b0;
      stackData_q <= `FSBE_PC_RESET;
    end else begin
      stackPush_q <= execNow && isCall;
      if (execNow && isCall) begin
        stackData_q <= pcNext;
      end
    end
  end

endmodule
`default_nettype wire
